// >>> hw/sarrd_defines.svh
// Constants for the serial readout sequencer of the 12-bit SAR converter
// Notes on behaviour
// - Select falling edge samples input, starts conversion
// - Result bits shift out during conversion
// - Frame is four zeros then 12 bits MSB-first
// - Select fall and falls 1-3 present zeros
// - Fourth clock fall presents MSB, then lower bits
// - Sixteenth clock fall floats the data output
// - Conversion completes on sixteenth clock fall
// - Acquisition starts at rise after 13th fall
// - Early select rise skips acquisition, next invalid
// - Select rise mid-frame aborts and floats output
// - Rise between falls 2 and 10 powers down
// - Dummy cycle over 10 falls wakes device
// - Full power needs 1 us after wake
`ifndef SARRD_DEFINES_SVH
`define SARRD_DEFINES_SVH

// =============================================================
// Frame layout
`define SARRD_FRAME_BITS   16
`define SARRD_LEAD_ZEROS   4
`define SARRD_RES_BITS     12
`define SARRD_LAST_FALL    5'h10
`define SARRD_ACQ_FALL     5'h0d
`define SARRD_PD_FIRST     5'h02
`define SARRD_PD_LAST      5'h0a
`define SARRD_WAKE_FALLS   5'h0a

// =============================================================
// Timing
`define SARRD_CLK_NS       40
`define SARRD_WAKE_NS      1000
`define SARRD_WAKE_CYC     ((`SARRD_WAKE_NS + `SARRD_CLK_NS - 1) / `SARRD_CLK_NS)
`define SARRD_QUIET_NS     40

`endif

// >>> hw/sarrd_pkg.sv
// Types shared by the serial readout sequencer
package sarrd_pkg;

    // =============================================================
    // Frame state, Gray coded along idle -> frame -> tail
    typedef enum logic [1:0] {
        SARRD_IDLE  = 2'b00,
        SARRD_FRAME = 2'b01,
        SARRD_TAIL  = 2'b11
    } sarrd_state_t;

    // =============================================================
    // Host-driven pins after synchronisation
    typedef struct packed {
        logic sel_n;  // Conversion select, active low
        logic sclk;   // Serial clock
    } sarrd_pins_t;

endpackage

// >>> hw/sarrd_top.sv
// Serial conversion and readout sequencer of a 12-bit SAR converter
`timescale 1ns/1ps
`include "sarrd_defines.svh"

module sarrd_top
    import sarrd_pkg::*;
#(
    parameter int RES_W = `SARRD_RES_BITS
) (
    // Clock and reset
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    // Host pins
    input  wire logic             select_n_in,
    input  wire logic             serial_clk_in,
    // Digitised analog input level
    input  wire logic [RES_W-1:0] analog_input_in,
    // Serial data pin
    output logic                  serial_data_out_out,
    output logic                  serial_data_oe_out,
    // Status
    output logic                  acquiring_out,
    output logic                  powered_down_out,
    output logic                  frame_valid_out
);

    localparam int FW = `SARRD_FRAME_BITS;

    // =============================================================
    // Synchronisers
    // The input level is read only at a select fall, and the host holds it
    // steady there, so a per-bit two-flop copy cannot tear the sample.
    sarrd_pins_t      pin_s1_q;   // First stage, read by second only
    sarrd_pins_t      pin_s2_q;   // Safe copy
    sarrd_pins_t      pin_s3_q;   // Delayed copy for edge finding
    logic [RES_W-1:0] ain_s1_q;   // Input level, first stage
    logic [RES_W-1:0] ain_s2_q;   // Input level, safe copy

    // Two flops per pin before any logic looks at it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_s1_q <= '{sel_n: 1'b1, sclk: 1'b0};
            pin_s2_q <= '{sel_n: 1'b1, sclk: 1'b0};
            pin_s3_q <= '{sel_n: 1'b1, sclk: 1'b0};
            ain_s1_q <= '0;
            ain_s2_q <= '0;
        end else begin
            pin_s1_q <= '{sel_n: select_n_in, sclk: serial_clk_in};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            ain_s1_q <= analog_input_in;
            ain_s2_q <= ain_s1_q;
        end
    end

    // Edge finders on the delayed and current synchronised copies;
    // a pin edge shows here two clk_in edges after it happens.
    function automatic logic went_low(input logic was, input logic cur);
        return was & ~cur;
    endfunction

    function automatic logic went_high(input logic was, input logic cur);
        return ~was & cur;
    endfunction

    // Edge events, one clk_in cycle each
    logic sel_fall;  // Select went low
    logic sel_rise;  // Select went high
    logic sck_fall;  // Serial clock fell
    logic sck_rise;  // Serial clock rose
    assign sel_fall = went_low(pin_s3_q.sel_n, pin_s2_q.sel_n);
    assign sel_rise = went_high(pin_s3_q.sel_n, pin_s2_q.sel_n);
    assign sck_fall = went_low(pin_s3_q.sclk, pin_s2_q.sclk);
    assign sck_rise = went_high(pin_s3_q.sclk, pin_s2_q.sclk);

    // =============================================================
    // Frame sequencing
    sarrd_state_t     state_q;  // Frame state
    logic [4:0]       fall_q;   // Clock falls seen this frame
    logic [FW-1:0]    word_q;   // Outgoing word, MSB at top
    logic             in_frame;     // Frame open and data driven
    logic [4:0]       fall_d;       // Count after this fall
    logic             frame_start;  // Select fall accepted from idle

    assign in_frame    = (state_q == SARRD_FRAME);
    assign fall_d      = fall_q + 5'h01;
    // A select fall outside idle is refused, so only this one opens a frame
    assign frame_start = (state_q == SARRD_IDLE) && sel_fall;

    // Select edges outrank clock edges seen in the same cycle
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SARRD_IDLE;
            fall_q  <= '0;
            word_q  <= '0;
        end else if (sel_rise) begin
            state_q <= SARRD_IDLE;
            fall_q  <= '0;
        end else begin
            unique case (state_q)
                // Waiting for the host to open a frame
                SARRD_IDLE: begin
                    if (sel_fall) begin
                        state_q <= SARRD_FRAME;
                        fall_q  <= '0;
                        // Leading zeros above the held sample
                        word_q  <= {{`SARRD_LEAD_ZEROS{1'b0}}, ain_s2_q};
                    end
                end
                // Shifting out while the conversion runs
                SARRD_FRAME: begin
                    if (sck_fall) begin
                        fall_q <= fall_d;
                        word_q <= {word_q[FW-2:0], 1'b0};
                        if (fall_d == `SARRD_LAST_FALL) begin
                            state_q <= SARRD_TAIL;
                        end
                    end
                end
                // Conversion done, output floated until select rises
                SARRD_TAIL: begin
                    if (sck_fall && fall_q != 5'h1f) begin
                        fall_q <= fall_d;  // Extra clocks only counted
                    end
                end
            endcase
        end
    end

    // =============================================================
    // Serial data pin
    // Drives word bit 15 at select fall, then one lower bit per fall
    // Data still shifts out while powered down; only the validity flag
    // tells the host that such a frame is not to be trusted.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            serial_data_out_out <= 1'b0;
            serial_data_oe_out  <= 1'b0;
        end else if (sel_rise) begin
            serial_data_oe_out  <= 1'b0;
            serial_data_out_out <= 1'b0;
        end else if (frame_start) begin
            serial_data_oe_out  <= 1'b1;
            serial_data_out_out <= 1'b0;
        end else if (in_frame && sck_fall) begin
            if (fall_d == `SARRD_LAST_FALL) begin
                serial_data_oe_out  <= 1'b0;
                serial_data_out_out <= 1'b0;
            end else begin
                // Falls 1-3 give zeros, fall 4 the MSB onward
                serial_data_out_out <= word_q[FW-2];
            end
        end
    end

    // =============================================================
    // Acquisition tracking
    // Acquisition lasts from the first rise after fall 13 to the next
    // sample; a select rise before it leaves the next frame unusable.
    // Blocked while powered down: the front end is asleep then.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            acquiring_out <= 1'b0;
        end else if (frame_start) begin
            acquiring_out <= 1'b0;  // Sampling ends acquisition
        end else if (state_q != SARRD_IDLE && !sel_rise && sck_rise
                     && fall_q >= `SARRD_ACQ_FALL && !powered_down_out) begin
            acquiring_out <= 1'b1;
        end
    end

    // Validity of the frame now being sent
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            frame_valid_out <= 1'b0;
        end else if (frame_start) begin
            // No acquisition in the last frame means stale charge
            frame_valid_out <= acquiring_out && !powered_down_out;
        end
    end

    // =============================================================
    // Power-down and wake-up
    localparam logic [5:0] WAKE_CYC = 6'(`SARRD_WAKE_CYC);
    logic       wake_arm_q;  // Dummy cycle passed its tenth fall
    logic [5:0] wake_cnt_q;  // Cycles since dummy select fall
    logic       pd_enter;

    // Window excludes the 10th fall itself; edge timing is the host's worry
    assign pd_enter = sel_rise && in_frame
                      && fall_q >= `SARRD_PD_FIRST && fall_q < `SARRD_PD_LAST;

    // Dummy-cycle progress and the power-up delay count
    // Arm drops on a fresh entry, so a cut dummy must start over
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wake_arm_q <= 1'b0;
            wake_cnt_q <= '0;
        end else if (!powered_down_out || pd_enter) begin
            wake_arm_q <= 1'b0;
            wake_cnt_q <= '0;
        end else if (frame_start) begin
            wake_cnt_q <= 6'h01;  // Delay counts from dummy select fall
        end else begin
            if (in_frame && sck_fall && fall_d > `SARRD_WAKE_FALLS) begin
                wake_arm_q <= 1'b1;
            end
            if (wake_cnt_q != 6'h00 && wake_cnt_q != WAKE_CYC) begin
                wake_cnt_q <= wake_cnt_q + 6'h01;
            end
        end
    end

    // Entry wins over a wake finishing in the same cycle,
    // since a host that cut the frame that early meant to sleep
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            powered_down_out <= 1'b0;
        end else if (pd_enter) begin
            powered_down_out <= 1'b1;
        end else if (wake_arm_q && wake_cnt_q == WAKE_CYC) begin
            powered_down_out <= 1'b0;
        end
    end

endmodule

// >>> sim/sarrd_host.sv
// Host model driving select and serial clock and capturing data
`timescale 1ns/1ps
module sarrd_host (
    // Clock
    input  wire logic clk_in,
    // Pins
    output logic      select_n_out,
    output logic      serial_clk_out,
    input  wire logic serial_data_in,
    input  wire logic serial_data_oe_in
);
    logic last_q = 1'b0;  // Last driven level
    // Floated pin shows the inverse, so a stale bit never matches
    wire  pin = serial_data_oe_in ? serial_data_in : ~last_q;
    always @(posedge clk_in) if (serial_data_oe_in) last_q <= serial_data_in;
    initial begin
        select_n_out = 1'b1;
        serial_clk_out = 1'b0;
    end
    // Wait n edges, then step just off the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Frame of n falls at 320 ns; clock stands low outside frames
    task automatic frame(input int n, output logic [15:0] word, output logic oe);
        word = 16'h0000;
        select_n_out = 1'b0;
        for (int k = 0; k < n; k++) begin
            cyc(4);
            serial_clk_out = 1'b1;
            cyc(1);
            word[15-k] = pin;
            cyc(3);
            serial_clk_out = 1'b0;
        end
        cyc(5);
        oe = serial_data_oe_in;
        select_n_out = 1'b1;
        cyc(6);
        if (n < 16) oe = serial_data_oe_in;
        cyc(2);
    endtask
endmodule

// >>> sim/sarrd_props.sv
// Port checks of the serial readout sequencer
`timescale 1ns/1ps
module sarrd_props
    import sarrd_pkg::*;
(
    // Clock, reset and host pins
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic select_n_in,
    input wire logic serial_clk_in,
    // Device outputs
    input wire logic serial_data_out_out,
    input wire logic serial_data_oe_out,
    input wire logic acquiring_out,
    input wire logic powered_down_out,
    input wire logic frame_valid_out
);
    // =============================================================
    // Timing frame
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_sel_rise; $rose(select_n_in); endsequence
    sequence s_floated; !serial_data_oe_out ##1 !serial_data_oe_out; endsequence
    // =============================================================
    // Properties
    // First reset edge may still show unknowns; check from the second one
    property p_reset_quiet;
        disable iff (1'b0) rst_in ##1 rst_in
            |-> !serial_data_oe_out && !powered_down_out && !frame_valid_out;
    endproperty
    property p_data_low_idle; !serial_data_oe_out |-> !serial_data_out_out; endproperty
    property p_float_on_rise; s_sel_rise |-> ##[1:6] s_floated; endproperty
    property p_start_zero;
        $rose(serial_data_oe_out) |-> (!serial_data_out_out && !select_n_in) [*8];
    endproperty
    property p_pd_entry; $rose(powered_down_out) |-> select_n_in && !serial_data_oe_out; endproperty
    property p_acq_in_frame; $rose(acquiring_out) |-> serial_data_oe_out; endproperty
    property p_wake_in_frame; $fell(powered_down_out) |-> !select_n_in; endproperty
    property p_valid_at_start;
        $changed(frame_valid_out) |-> !select_n_in ##[0:1] serial_data_oe_out;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("outputs active in reset");
    a_data_low_idle: assert property (p_data_low_idle) else $error("data high while floated");
    a_float_on_rise: assert property (p_float_on_rise) else $error("no float on select");
    a_start_zero: assert property (p_start_zero) else $error("lead bits not zero");
    a_pd_entry: assert property (p_pd_entry) else $error("bad power-down entry");
    a_acq_in_frame: assert property (p_acq_in_frame) else $error("acquire outside frame");
    a_wake_in_frame: assert property (p_wake_in_frame) else $error("wake outside frame");
    a_valid_at_start: assert property (p_valid_at_start) else $error("valid moved late");
endmodule

// >>> sim/sarrd_top_bench.sv
// Self-checking bench of the serial readout sequencer
`timescale 1ns/1ps
module sarrd_top_bench;
    import sarrd_pkg::*;
    logic        clk_in = 1'b0;
    logic        rst_in = 1'b1;
    logic [11:0] analog_input_in = 12'h000;
    wire         sel_n, sclk, serial_data_out, oe, acq, pd, fv;
    int          num_errors = 0;
    int          tests_run = 0;
    int          seed = 32'h777948ff;
    int          acq_m = 0;  // Model: last frame reached acquisition
    int          pd_m = 0;   // Model: powered down
    int          seq[] = '{16, 16, 16, 16, 14, 16, 12, 16, 1, 16, 10, 16,
                            2, 4, 12, 16, 16, 9, 16, 16, 16};
    sarrd_top sarrd_top_i (.clk_in(clk_in), .rst_in(rst_in), .select_n_in(sel_n),
        .serial_clk_in(sclk), .analog_input_in(analog_input_in),
        .serial_data_out_out(serial_data_out), .serial_data_oe_out(oe), .acquiring_out(acq),
        .powered_down_out(pd), .frame_valid_out(fv));
    sarrd_host sarrd_host_i (.clk_in(clk_in), .select_n_out(sel_n), .serial_clk_out(sclk),
        .serial_data_in(serial_data_out), .serial_data_oe_in(oe));
    initial forever #20 clk_in = ~clk_in;
    // Count and report one comparison
    task automatic cmp(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d, errors %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // One frame against the model
    task automatic run(input int n);
        logic [15:0] word;
        logic        oe_end;
        int          r;
        r = $random(seed);
        analog_input_in = r[11:0];
        sarrd_host_i.cyc(3);
        sarrd_host_i.frame(n, word, oe_end);
        cmp("frame_valid", 16'(acq_m != 0 && pd_m == 0), {15'h0000, fv});
        // Cut frames are checked on the bits that were clocked out
        cmp("word", {4'h0, r[11:0]} & ~(16'hffff >> n), word);
        cmp("oe_end", 16'h0000, {15'h0000, oe_end});
        // A dummy of 14 or more falls wakes at fall 11 and then acquires
        acq_m = (n >= 14) ? 1 : 0;
        cmp("acquiring", 16'(acq_m), {15'h0000, acq});
        if (pd_m == 0 && n >= 2 && n <= 9) pd_m = 1;
        else if (pd_m != 0 && n >= 11) pd_m = 0;
        cmp("powered_down", 16'(pd_m), {15'h0000, pd});
    endtask
    initial begin
        sarrd_host_i.cyc(6);
        cmp("oe_reset", 16'h0000, {15'h0000, oe});
        rst_in = 1'b0;
        foreach (seq[i]) run(seq[i]);
        end_of_test();
    end
    // Hang guard
    initial begin
        #1000000;
        num_errors++;
        end_of_test();
    end
endmodule
bind sarrd_top sarrd_props sarrd_props_i (.clk_in(clk_in), .rst_in(rst_in),
    .select_n_in(select_n_in), .serial_clk_in(serial_clk_in),
    .serial_data_out_out(serial_data_out_out), .serial_data_oe_out(serial_data_oe_out),
    .acquiring_out(acquiring_out), .powered_down_out(powered_down_out),
    .frame_valid_out(frame_valid_out));
